// file: hw/cbi_pkg.sv
package cbi_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TACH_PULSE_NS = 10000;
    localparam int TACH_PULSE_CYCLES =
        (TACH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] TACH_LOAD = 10'(TACH_PULSE_CYCLES - 1);
    localparam logic [9:0] TACH_IDLE = 10'h000;

    // Oscillator periods of blanking and of dead time
    localparam logic [1:0] BLANK_OSC_CYCLES = 2'h2;
    localparam logic [1:0] DEAD_OSC_CYCLES = 2'h2;

    // Field positions in the synchronised pin vector
    localparam int IN_W = 6;
    localparam int IN_POS_LSB = 0;
    localparam int IN_POS_MSB = 2;
    localparam int IN_DIR = 3;
    localparam int IN_QUAD = 4;
    localparam int IN_OSC = 5;

    // Drive indices inside the six interlock flags
    localparam int PHASES = 3;
    localparam int DRIVES = 6;

    // Reset values
    localparam logic [IN_W-1:0] RST_PINS = 6'h00;
    localparam logic [2:0] HIGH_OFF_N = 3'h7;
    localparam logic [2:0] DRIVE_OFF = 3'h0;
    localparam logic [5:0] FLAGS_CLEAR = 6'h00;
    localparam logic [2:0] POS_RESET = 3'h0;
    localparam logic [1:0] CNT_RESET = 2'h0;

    // Position latch state, Gray coded
    typedef enum logic [0:0] {
        LATCH_OPEN = 1'b0,
        LATCH_FROZEN = 1'b1
    } cbi_latch_t;

endpackage

// file: hw/cbi_if.sv
interface cbi_if;
    logic ce;
    logic osc_tick;
    logic [2:0] req_high;
    logic [2:0] req_low;
    logic [2:0] drive_high;
    logic [2:0] drive_low;
    logic [5:0] interlock;

    modport ctrl (
        output ce,
        output osc_tick,
        output req_high,
        output req_low,
        input drive_high,
        input drive_low,
        input interlock
    );

    modport dt (
        input ce,
        input osc_tick,
        input req_high,
        input req_low,
        output drive_high,
        output drive_low,
        output interlock
    );
endinterface

// file: hw/cbi_deadtime.sv
module cbi_deadtime (
    input wire logic clk_i,
    input wire logic resetn_i,
    cbi_if.dt bus
);

    typedef struct packed {
        logic [2:0] drive_high;
        logic [2:0] drive_low;
        logic [5:0] flag;
        logic [5:0][1:0] cnt;
    } cbi_dt_state_t;

    cbi_dt_state_t st;
    cbi_dt_state_t next_st;
    logic [5:0] on;

    // Gate each request by the opposing flag, then age the flags
    always_comb begin
        on = cbi_pkg::FLAGS_CLEAR;
        next_st = st;
        for (int p = 0; p < cbi_pkg::PHASES; p++) begin
            on[p] = bus.req_high[p] & ~st.flag[p + cbi_pkg::PHASES]
                & ~bus.req_low[p];
            on[p + cbi_pkg::PHASES] = bus.req_low[p] & ~st.flag[p]
                & ~bus.req_high[p];
        end
        for (int d = 0; d < cbi_pkg::DRIVES; d++) begin
            if (on[d]) begin
                next_st.flag[d] = 1'b1;
                next_st.cnt[d] = cbi_pkg::CNT_RESET;
            end else if (st.flag[d] && bus.osc_tick) begin
                if (st.cnt[d] == cbi_pkg::DEAD_OSC_CYCLES - 2'h1) begin
                    next_st.flag[d] = 1'b0;
                    next_st.cnt[d] = cbi_pkg::CNT_RESET;
                end else begin
                    next_st.cnt[d] = st.cnt[d] + 2'h1;
                end
            end
        end
        next_st.drive_high = on[2:0];
        next_st.drive_low = on[5:3];
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else if (bus.ce) begin
            st <= next_st;
        end
    end

    assign bus.drive_high = st.drive_high;
    assign bus.drive_low = st.drive_low;
    assign bus.interlock = st.flag;

endmodule

// file: hw/cbi_top.sv
module cbi_top (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic position_in_1_i,
    input wire logic position_in_2_i,
    input wire logic position_in_3_i,
    input wire logic dir_i,
    input wire logic quad_sel_i,
    input wire logic pwm_osc_i,
    input wire logic pwm_on_i,
    output logic [2:0] high_drive_n_o,
    output logic [2:0] low_drive_o,
    output logic [5:0] interlock_o,
    output logic tach_o
);

    typedef struct packed {
        logic [cbi_pkg::IN_W-1:0] sync1;
        logic [cbi_pkg::IN_W-1:0] sync2;
        logic [cbi_pkg::IN_W-1:0] sync3;
        logic [cbi_pkg::IN_W-1:0] filt;
        logic osc_prev;
        logic osc_tick;
        cbi_pkg::cbi_latch_t latch;
        logic [2:0] pos;
        logic [1:0] blank_cnt;
        logic [9:0] tach_cnt;
        logic tach;
        logic [2:0] high_n;
        logic [2:0] low;
        logic [5:0] flags;
    } cbi_top_state_t;

    cbi_top_state_t st;
    cbi_top_state_t next_st;

    cbi_if bus ();

    logic [5:0] dec;
    logic [2:0] pin_pos;
    logic pos_change;
    logic [2:0] req_high;
    logic [2:0] req_low;

    // Take a bit over only where the second and third stages agree
    function automatic logic [cbi_pkg::IN_W-1:0] settle(
        input logic [cbi_pkg::IN_W-1:0] held,
        input logic [cbi_pkg::IN_W-1:0] s2,
        input logic [cbi_pkg::IN_W-1:0] s3
    );
        logic [cbi_pkg::IN_W-1:0] agree;
        agree = ~(s2 ^ s3);
        settle = (agree & s2) | (~agree & held);
    endfunction

    // Commutation table: {high on A..C, low on A..C}, bit 0 is phase A
    // Code order is {position 1, position 2, position 3}
    function automatic logic [5:0] commutate(
        input logic dir,
        input logic [2:0] code
    );
        commutate = 6'h00;
        if (dir) begin
            unique case (code)
                3'h1: commutate = {3'h1, 3'h2};
                3'h3: commutate = {3'h1, 3'h4};
                3'h2: commutate = {3'h2, 3'h4};
                3'h6: commutate = {3'h2, 3'h1};
                3'h4: commutate = {3'h4, 3'h1};
                3'h5: commutate = {3'h4, 3'h2};
                default: commutate = 6'h00;
            endcase
        end else begin
            unique case (code)
                3'h5: commutate = {3'h2, 3'h4};
                3'h4: commutate = {3'h1, 3'h4};
                3'h6: commutate = {3'h1, 3'h2};
                3'h2: commutate = {3'h4, 3'h2};
                3'h3: commutate = {3'h4, 3'h1};
                3'h1: commutate = {3'h2, 3'h1};
                default: commutate = 6'h00;
            endcase
        end
    endfunction

    // Settled position code and change against the latched code
    assign pin_pos = st.filt[cbi_pkg::IN_POS_MSB:cbi_pkg::IN_POS_LSB];
    assign pos_change = (pin_pos != st.pos);

    // Drive requests from the latched position
    always_comb begin
        dec = commutate(st.filt[cbi_pkg::IN_DIR], st.pos);
        if (st.filt[cbi_pkg::IN_QUAD]) begin
            req_high = dec[5:3] & {3{pwm_on_i}};
            req_low = dec[2:0] & {3{pwm_on_i}};
        end else begin
            req_high = dec[5:3];
            req_low = dec[2:0] & {3{pwm_on_i}};
        end
    end

    // Next state of synchronisers, latch, tach and outputs
    always_comb begin
        next_st = st;

        // Three stage pin synchroniser
        next_st.sync1 = {pwm_osc_i, quad_sel_i, dir_i,
                         position_in_1_i, position_in_2_i, position_in_3_i};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.filt = settle(st.filt, st.sync2, st.sync3);

        // One pulse per completed oscillator period
        next_st.osc_prev = st.filt[cbi_pkg::IN_OSC];
        next_st.osc_tick = st.filt[cbi_pkg::IN_OSC] & ~st.osc_prev;

        // Tach pulse runs down to idle
        if (st.tach_cnt != cbi_pkg::TACH_IDLE) begin
            next_st.tach_cnt = st.tach_cnt - 10'h001;
        end else begin
            next_st.tach = 1'b0;
        end

        // Position latch, transparent or blanked
        unique case (st.latch)
            cbi_pkg::LATCH_OPEN: begin
                if (pos_change && !st.tach) begin
                    next_st.pos = pin_pos;
                    next_st.latch = cbi_pkg::LATCH_FROZEN;
                    next_st.blank_cnt = cbi_pkg::CNT_RESET;
                    next_st.tach_cnt = cbi_pkg::TACH_LOAD;
                    next_st.tach = 1'b1;
                end
            end
            cbi_pkg::LATCH_FROZEN: begin
                if (st.osc_tick) begin
                    if (st.blank_cnt ==
                        cbi_pkg::BLANK_OSC_CYCLES - 2'h1) begin
                        next_st.latch = cbi_pkg::LATCH_OPEN;
                        next_st.blank_cnt = cbi_pkg::CNT_RESET;
                    end else begin
                        next_st.blank_cnt = st.blank_cnt + 2'h1;
                    end
                end
            end
        endcase

        // Registered copies of the interlocked drives
        next_st.high_n = ~bus.drive_high;
        next_st.low = bus.drive_low;
        next_st.flags = bus.interlock;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '{
                sync1: cbi_pkg::RST_PINS,
                sync2: cbi_pkg::RST_PINS,
                sync3: cbi_pkg::RST_PINS,
                filt: cbi_pkg::RST_PINS,
                osc_prev: 1'b0,
                osc_tick: 1'b0,
                latch: cbi_pkg::LATCH_OPEN,
                pos: cbi_pkg::POS_RESET,
                blank_cnt: cbi_pkg::CNT_RESET,
                tach_cnt: cbi_pkg::TACH_IDLE,
                tach: 1'b0,
                high_n: cbi_pkg::HIGH_OFF_N,
                low: cbi_pkg::DRIVE_OFF,
                flags: cbi_pkg::FLAGS_CLEAR
            };
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Link to the interlock stage
    assign bus.ce = ce_i;
    assign bus.osc_tick = st.osc_tick;
    assign bus.req_high = req_high;
    assign bus.req_low = req_low;

    // Dead time and cross conduction interlock
    cbi_deadtime u_deadtime (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .bus(bus)
    );

    // Outputs straight from state flops
    assign high_drive_n_o = st.high_n;
    assign low_drive_o = st.low;
    assign interlock_o = st.flags;
    assign tach_o = st.tach;

endmodule

// file: sim/cbi_monitor.sv
module cbi_monitor (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic position_in_1_i,
    input wire logic position_in_2_i,
    input wire logic position_in_3_i,
    input wire logic dir_i,
    input wire logic quad_sel_i,
    input wire logic pwm_osc_i,
    input wire logic pwm_on_i,
    input wire logic [2:0] high_drive_n_o,
    input wire logic [2:0] low_drive_o,
    input wire logic [5:0] interlock_o,
    input wire logic tach_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic osc_q;
    logic rise;
    logic [10:0] tcnt;
    logic [2:0][1:0] hoff;
    logic [2:0][1:0] loff;
    logic [2:0] hz;
    logic [2:0] lz;
    logic [5:0] drv;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Drives as on-high flags, in interlock order
    assign drv = {low_drive_o, ~high_drive_n_o};
    assign rise = pwm_osc_i && !osc_q;
    // No oscillator rise yet since that drive went off
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            hz[i] = hoff[i] == 2'h0;
            lz[i] = loff[i] == 2'h0;
        end
    end
    // Tach width and oscillator rises seen while each drive is off
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_q <= 1'b0;
            tcnt <= 11'h000;
            hoff <= '1;
            loff <= '1;
        end else begin
            osc_q <= pwm_osc_i;
            tcnt <= tach_o ? tcnt + 11'(ce_i) : 11'h000;
            for (int i = 0; i < 3; i++) begin
                hoff[i] <= drv[i] ? 2'h0 : hoff[i] + 2'(rise && !hoff[i][1]);
                loff[i] <= drv[i+3] ? 2'h0 : loff[i] + 2'(rise && !loff[i][1]);
            end
        end
    end
    AST_NO_SHOOT: assert property (
        (low_drive_o & ~high_drive_n_o) == 3'h0)
        else $error("both drives of one phase on");
    AST_LOW_ONE: assert property ($onehot0(low_drive_o))
        else $error("more than one low drive on");
    AST_HIGH_ONE: assert property ($onehot0(~high_drive_n_o))
        else $error("more than one high drive on");
    AST_DEAD_LOW: assert property (
        (low_drive_o & ~$past(low_drive_o) & hz) == 3'h0)
        else $error("low drive on without dead time");
    AST_DEAD_HIGH: assert property (
        (drv[2:0] & ~$past(drv[2:0]) & lz) == 3'h0)
        else $error("high drive on without dead time");
    AST_FLAG_SET: assert property (($past(drv) & ~interlock_o) == 6'h00)
        else $error("interlock flag missing for drive");
    AST_FLAG_HOLD: assert property (($past(interlock_o) & ~interlock_o
        & ($past(drv) | $past(drv, 2))) == 6'h00)
        else $error("interlock flag cleared too early");
    AST_TACH_WIDTH: assert property ($fell(tach_o) |->
        tcnt == 11'(cbi_pkg::TACH_PULSE_CYCLES))
        else $error("tach pulse width wrong");
    AST_CMT_TACH: assert property ($changed(high_drive_n_o) && !quad_sel_i
        && !$past(quad_sel_i, 8) |-> tach_o)
        else $error("commutation without tach pulse");
endmodule

bind cbi_top cbi_monitor cbi_monitor_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .position_in_1_i(position_in_1_i),
    .position_in_2_i(position_in_2_i), .position_in_3_i(position_in_3_i),
    .dir_i(dir_i), .quad_sel_i(quad_sel_i), .pwm_osc_i(pwm_osc_i),
    .pwm_on_i(pwm_on_i), .high_drive_n_o(high_drive_n_o),
    .low_drive_o(low_drive_o), .interlock_o(interlock_o), .tach_o(tach_o));

// file: sim/cbi_hall_model.sv
module cbi_hall_model #(
    parameter int OSC_HALF = 50
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] code_i,
    output logic [2:0] hall_o,
    output logic osc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Sensors follow the rotor code; oscillator runs free
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hall_o <= 3'h0;
            cnt <= 0;
            osc_o <= 1'b0;
        end else begin
            hall_o <= code_i;
            cnt <= (cnt == OSC_HALF - 1) ? 0 : cnt + 1;
            osc_o <= (cnt == OSC_HALF - 1) ? ~osc_o : osc_o;
        end
    end
endmodule

// file: sim/tb.sv
`define CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) begin \
            $display("Error %s expected %h seen %h", nm, ex, got); \
            num_errors++; \
        end \
    end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i;
    logic resetn_i;
    logic ce_i;
    logic dir_i;
    logic quad_sel_i;
    logic pwm_on_i;
    logic osc;
    logic [2:0] code;
    logic [2:0] hall;
    logic [2:0] high_drive_n_o;
    logic [2:0] low_drive_o;
    logic [5:0] interlock_o;
    logic tach_o;
    int num_errors = 0;
    int checks = 0;
    // Expected {low, high} drives per code, for each direction
    logic [5:0] tab1 [8] = '{6'h00, 6'h11, 6'h22, 6'h21,
        6'h0c, 6'h14, 6'h0a, 6'h00};
    logic [5:0] tab0 [8] = '{6'h00, 6'h0a, 6'h14, 6'h0c,
        6'h21, 6'h22, 6'h11, 6'h00};
    logic [2:0] seq [8] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h7, 3'h0};

    cbi_hall_model cbi_hall_model_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .code_i(code), .hall_o(hall), .osc_o(osc));
    cbi_top cbi_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .position_in_1_i(hall[2]), .position_in_2_i(hall[1]),
        .position_in_3_i(hall[0]), .dir_i(dir_i), .quad_sel_i(quad_sel_i),
        .pwm_osc_i(osc), .pwm_on_i(pwm_on_i), .high_drive_n_o(high_drive_n_o),
        .low_drive_o(low_drive_o), .interlock_o(interlock_o), .tach_o(tach_o));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic exp_drv(input logic [5:0] e);
        `CHK("low_drive", e[5:3], low_drive_o)
        `CHK("high_drive_n", ~e[2:0], high_drive_n_o)
    endtask

    // Bounded wait for tach to reach a level
    task automatic wait_tach(input logic lvl, input int lim);
        for (int i = 0; i < lim && tach_o !== lvl; i++) @(negedge clk_i);
        `CHK("tach", lvl, tach_o)
    endtask

    task automatic commute(input logic [2:0] c);
        @(posedge clk_i);
        code <= c;
        wait_tach(1'b1, 20);
    endtask

    task automatic settle();
        wait_tach(1'b0, 1100);
        cyc(20);
    endtask

    // Every code in both directions, invalid codes last
    task automatic t_walk();
        for (int d = 1; d >= 0; d--) begin
            @(posedge clk_i);
            dir_i <= d[0];
            for (int k = 0; k < 8; k++) begin
                commute(seq[k]);
                settle();
                exp_drv(d[0] ? tab1[seq[k]] : tab0[seq[k]]);
            end
        end
    endtask

    // Phase A swaps from high to low and must wait out the dead time
    task automatic t_dead();
        @(posedge clk_i);
        dir_i <= 1'b1;
        commute(3'h1);
        settle();
        commute(3'h4);
        cyc(4);
        `CHK("low_drive", 3'h0, low_drive_o)
        `CHK("high_drive_n", 3'h3, high_drive_n_o)
        `CHK("interlock", 6'h15, interlock_o)
        cyc(60);
        `CHK("low_drive", 3'h0, low_drive_o)
        settle();
        exp_drv(tab1[4]);
        `CHK("interlock", 6'h0c, interlock_o)
    endtask

    // Clock enable low freezes everything, pins included
    task automatic t_hold();
        @(posedge clk_i);
        ce_i <= 1'b0;
        code <= 3'h2;
        cyc(40);
        `CHK("tach", 1'b0, tach_o)
        exp_drv(tab1[6]);
        @(posedge clk_i);
        ce_i <= 1'b1;
        wait_tach(1'b1, 20);
        settle();
        exp_drv(tab1[2]);
        commute(3'h6);
        settle();
        exp_drv(tab1[6]);
    endtask

    // A second change inside the pulse waits and loads once it ends
    task automatic t_blank();
        commute(3'h5);
        cyc(30);
        @(posedge clk_i);
        code <= 3'h6;
        cyc(10);
        exp_drv(tab1[5]);
        wait_tach(1'b0, 1100);
        wait_tach(1'b1, 20);
        settle();
        exp_drv(tab1[6]);
    endtask

    task automatic quad(input logic q, input logic p, input logic [5:0] e);
        @(posedge clk_i);
        quad_sel_i <= q;
        pwm_on_i <= p;
        cyc(20);
        exp_drv(e);
    endtask

    initial begin
        resetn_i = 1'b0;
        ce_i = 1'b1;
        dir_i = 1'b1;
        quad_sel_i = 1'b0;
        pwm_on_i = 1'b1;
        code = 3'h0;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        cyc(2);
        exp_drv(6'h00);
        `CHK("interlock", 6'h00, interlock_o)
        t_walk();
        t_dead();
        t_blank();
        t_hold();
        quad(1'b0, 1'b0, 6'h02);
        quad(1'b1, 1'b0, 6'h00);
        quad(1'b1, 1'b1, 6'h0a);
        quad(1'b0, 1'b1, 6'h0a);
        end_sim();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        end_sim();
    end
endmodule
